// file: logic/monitor_irq_cfg.svh
// Offsets, field positions, reset values and counts of the monitor interrupt block
`ifndef MONITOR_IRQ_CFG_SVH
`define MONITOR_IRQ_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_MAIN_CFG 8'h00
`define OFS_PIN_CFG 8'h07
`define OFS_GPIO_CFG_FIRST 8'h08
`define OFS_GPIO_CFG_LAST 8'h0b
`define OFS_THERMAL_ALARM_N_LIM_FIRST 8'h0d
`define OFS_THERMAL_ALARM_N_LIM_SECOND 8'h0e
`define OFS_THERMAL_ALARM_N_LIM_THIRD 8'h0f
`define OFS_MASK_FIRST 8'h18
`define OFS_MASK_LAST 8'h1d
`define OFS_STAT_ONE 8'h20
`define OFS_STAT_TWO 8'h21
`define OFS_STAT_THREE 8'h22
`define OFS_EVENT_STAT_FOUR 8'h23
`define OFS_STAT_FIVE 8'h24
`define OFS_STAT_SIX 8'h25

// ****************************************
// Field positions
// ****************************************
`define MAIN_INT_ENABLE 1
`define MAIN_INT_CLEAR 2
`define MAIN_THERMAL_ALARM_N_ENABLE 4
`define MAIN_AFC_DAC 5
`define MAIN_AFC_PWM 6
`define PIN_SEVENTEEN_GPIO 0
`define PIN_INTRUSION_CLEAR 1
`define PIN_SEVENTEEN_DIR 6
`define PIN_SEVENTEEN_POL 7
`define S4_TEMP_BIT 0
`define S4_THERMAL_ALARM_N_BIT 3
`define S4_AFC_BIT 4
`define S4_INTRUSION_BIT 6
`define S4_PIN_SEVENTEEN_BIT 7

// ****************************************
// Reset values and counts
// ****************************************
`define RST_MAIN_CFG 8'h00
`define RST_PIN_CFG 8'h00
`define RST_GPIO_CFG 8'h00
`define RST_MASK 8'h00
`define RST_THERMAL_ALARM_N_LIM 8'h50
`define THERMAL_ALARM_N_HYST_DEGC 9'sd5
`define HOLDOFF_LOCAL_CONV 2'd2
`define LOCAL_SENSOR 2'd2
`define NO_SENSOR 2'd3

`endif

// file: logic/monitor_irq_pkg.sv
// Types shared by the monitor interrupt block and its surroundings
package monitor_irq_pkg;

   // One finished analog or temperature conversion
   typedef struct packed {
      logic valid;
      logic [4:0] channel;
      logic [1:0] sensor;
      logic [7:0] value;
      logic [7:0] high_limit;
      logic [7:0] low_limit;
   } meas_s;

   // One finished fan period count
   typedef struct packed {
      logic valid;
      logic [2:0] index;
      logic [7:0] count;
      logic [7:0] limit;
   } fan_s;

   // Register access from the management bus engine
   typedef struct packed {
      logic write;
      logic read;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_s;

endpackage

// file: logic/monitor_interrupt_and_thermal_alarm.sv
// Interrupt aggregation and thermal alarm of the system monitor
// What this block does
// - Out of limit: above high, at/below low
// - Analog status rewritten by every measurement on channels 0 to 16
// - Clear bit and alert response keep limit status bits
// - Mask bit one hides its status bit
// - Masked analog bits set latch driving interrupt
// - Analog latch held off two local conversions
// - Fan start/stop under auto control sets event
// - Alarm change sets event bit, one interrupt
// - Alarm change sets causing channel status bit
// - Fan under-speed sets status, own masked latch
// - Fan latch waits for fan cycle end
// - Pin and intrusion events set status bits
// - Pin and intrusion sources unlatched, uncleared
// - Interrupt enabled only: enable set, clear zero
// - First status read clears interrupt and other banks
// - Alert response address clears interrupt
// - Writing clear bit clears interrupt
// - Alarm from dedicated thermal limits only
// - Alarm enable forces cooling outputs full
// - Alarm releases when all 3 at/below limit minus 5
// - Alarm interrupt only on alarm change
// - External alarm low forces full; gpio ignores
// - Intrusion sticks until clear bit written
// - Output pins auto-masked, seventeenth too
`timescale 1ns/1ps
`default_nettype none
`include "monitor_irq_cfg.svh"

module monitor_interrupt_and_thermal_alarm #(
   parameter int NUM_GPIO = 16
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire monitor_irq_pkg::reg_req_s i_reg,
   input wire monitor_irq_pkg::meas_s i_meas,
   input wire monitor_irq_pkg::fan_s i_fan,
   input wire logic i_fan_cycle_end,
   input wire logic i_monitor_cycle_end,
   input wire logic i_fan_start_stop,
   input wire logic i_ara_received,
   input wire logic [NUM_GPIO-1:0] i_gpio_pins,
   input wire logic i_thermal_alarm_n,
   input wire logic i_intrusion_input,
   output logic [7:0] o_reg_rdata,
   output logic o_int_n_out,
   output logic o_int_n_oe,
   output logic o_thermal_alarm_n_out,
   output logic o_thermal_alarm_n_oe,
   output logic o_force_full_scale
);
   import monitor_irq_pkg::*;

   // ****************************************
   // Storage
   // ****************************************
   logic [7:0] main_configuration_reg, pin_function_configuration_reg;
   logic [7:0] thermal_alarm_n_lim_reg [3];
   logic [7:0] mask_reg [6];
   logic [7:0] gpio_cfg_reg [4];
   logic [NUM_GPIO-1:0] gpio_wr_reg;
   logic [16:0] an_stat_reg;
   logic [7:0] fan_stat_reg;
   logic afc_stat_reg, thermal_alarm_n_stat_reg, intr_stat_reg;
   logic [2:0] over_reg;
   logic alarm_reg;
   logic an_latch_reg, fan_latch_reg, evt_latch_reg;
   logic [1:0] holdoff_reg;
   logic fan_hold_reg;
   logic [NUM_GPIO+1:0] pin_meta_reg, pin_sync_reg;

   // ****************************************
   // Decode and clear sources
   // ****************************************
   logic stat1_read, int_clear;
   assign stat1_read = i_reg.read && i_reg.addr == `OFS_STAT_ONE;
   assign int_clear = stat1_read || i_ara_received
      || (i_reg.write && i_reg.addr == `OFS_MAIN_CFG && i_reg.wdata[`MAIN_INT_CLEAR]);

   // Pins come from outside the clock domain; only the second stage is read
   always_ff @(posedge i_clock) begin
      // Reset to the idle pin levels so no false alarm or pin event follows reset
      if (i_rst) begin
         pin_meta_reg <= {1'b0, 1'b1, {NUM_GPIO{1'b1}}};
         pin_sync_reg <= {1'b0, 1'b1, {NUM_GPIO{1'b1}}};
      end else begin
         pin_meta_reg <= {i_intrusion_input, i_thermal_alarm_n, i_gpio_pins};
         pin_sync_reg <= pin_meta_reg;
      end
   end

   logic intr_pin, pin17_pin, pin17_gpio;
   logic [NUM_GPIO-1:0] gpio_pin;
   assign gpio_pin = pin_sync_reg[NUM_GPIO-1:0];
   assign pin17_pin = pin_sync_reg[NUM_GPIO];
   assign intr_pin = pin_sync_reg[NUM_GPIO+1];
   assign pin17_gpio = pin_function_configuration_reg[`PIN_SEVENTEEN_GPIO];

   // ****************************************
   // Limit comparison and thermal alarm
   // ****************************************
   logic is_temp, meas_out;
   logic [2:0] over_next;
   logic alarm_next, thermal_alarm_n_change;
   logic [4:0] cause_ch;
   // Temperatures are two's complement, voltages unsigned
   always_comb begin
      is_temp = i_meas.sensor != `NO_SENSOR;
      if (is_temp) begin
         meas_out = ($signed(i_meas.value) > $signed(i_meas.high_limit))
            || ($signed(i_meas.value) <= $signed(i_meas.low_limit));
      end else begin
         meas_out = (i_meas.value > i_meas.high_limit)
            || (i_meas.value <= i_meas.low_limit);
      end
   end

   // Per-sensor over flag with fixed hysteresis; only dedicated limits count
   always_comb begin
      over_next = over_reg;
      if (i_meas.valid && is_temp) begin
         if ($signed(i_meas.value) > $signed(thermal_alarm_n_lim_reg[i_meas.sensor])) begin
            over_next[i_meas.sensor] = 1'b1;
         end else if ($signed({i_meas.value[7], i_meas.value}) <=
               $signed({thermal_alarm_n_lim_reg[i_meas.sensor][7], thermal_alarm_n_lim_reg[i_meas.sensor]})
               - `THERMAL_ALARM_N_HYST_DEGC) begin
            over_next[i_meas.sensor] = 1'b0;
         end
      end
      alarm_next = |over_next;
      thermal_alarm_n_change = alarm_next != alarm_reg;
      cause_ch = (i_meas.sensor == 2'd2) ? 5'd16 : {3'd0, i_meas.sensor};
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         over_reg <= '0;
         alarm_reg <= 1'b0;
      end else begin
         over_reg <= over_next;
         alarm_reg <= alarm_next;
      end
   end

   // ****************************************
   // Analog status and latch
   // ****************************************
   // First status read wipes the other banks; the new result still lands
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         an_stat_reg <= '0;
      end else begin
         if (stat1_read) begin
            an_stat_reg[16:8] <= '0;
         end
         if (i_meas.valid && i_meas.channel < 5'd17) begin
            an_stat_reg[i_meas.channel] <= meas_out;
         end
         if (thermal_alarm_n_change) begin
            an_stat_reg[cause_ch] <= 1'b1;
         end
      end
   end

   logic an_masked;
   assign an_masked = |(an_stat_reg & ~{mask_reg[3][`S4_TEMP_BIT], mask_reg[1], mask_reg[0]});

   // After a clear the latch waits for two local conversions; here clear beats set
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         an_latch_reg <= 1'b0;
         holdoff_reg <= `HOLDOFF_LOCAL_CONV;
      end else if (int_clear) begin
         an_latch_reg <= 1'b0;
         holdoff_reg <= 2'd0;
      end else begin
         if (i_meas.valid && i_meas.sensor == `LOCAL_SENSOR
               && holdoff_reg != `HOLDOFF_LOCAL_CONV) begin
            holdoff_reg <= holdoff_reg + 2'd1;
         end
         if (holdoff_reg == `HOLDOFF_LOCAL_CONV && an_masked) begin
            an_latch_reg <= 1'b1;
         end
      end
   end

   // ****************************************
   // Fan status and latch
   // ****************************************
   logic fan_masked;
   assign fan_masked = |(fan_stat_reg & ~mask_reg[2]);

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         fan_stat_reg <= '0;
      end else begin
         if (stat1_read) begin
            fan_stat_reg <= '0;
         end
         if (i_fan.valid) begin
            fan_stat_reg[i_fan.index] <= i_fan.count > i_fan.limit;
         end
      end
   end

   // Hold released by the end of the fan cycle that follows the clear
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         fan_latch_reg <= 1'b0;
         fan_hold_reg <= 1'b0;
      end else if (int_clear) begin
         fan_latch_reg <= 1'b0;
         fan_hold_reg <= 1'b1;
      end else begin
         if (i_fan_cycle_end) begin
            fan_hold_reg <= 1'b0;
         end
         if (!fan_hold_reg && fan_masked) begin
            fan_latch_reg <= 1'b1;
         end
      end
   end

   // ****************************************
   // One-off events: fan start/stop and alarm change
   // ****************************************
   logic afc_event;
   assign afc_event = i_fan_start_stop
      && (main_configuration_reg[`MAIN_AFC_DAC] || main_configuration_reg[`MAIN_AFC_PWM]);

   // Set wins over the cycle-end or read clear so no event is lost
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         afc_stat_reg <= 1'b0;
         thermal_alarm_n_stat_reg <= 1'b0;
      end else begin
         if (afc_event) begin
            afc_stat_reg <= 1'b1;
         end else if (i_monitor_cycle_end || stat1_read) begin
            afc_stat_reg <= 1'b0;
         end
         if (thermal_alarm_n_change) begin
            thermal_alarm_n_stat_reg <= 1'b1;
         end else if (i_monitor_cycle_end || stat1_read) begin
            thermal_alarm_n_stat_reg <= 1'b0;
         end
      end
   end

   // Edge-driven latch: a steady alarm never re-raises it after a clear
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         evt_latch_reg <= 1'b0;
      end else if ((afc_event && !mask_reg[3][`S4_AFC_BIT])
            || (thermal_alarm_n_change && !mask_reg[3][`S4_THERMAL_ALARM_N_BIT])) begin
         evt_latch_reg <= 1'b1;
      end else if (int_clear) begin
         evt_latch_reg <= 1'b0;
      end
   end

   // ****************************************
   // General pins and intrusion
   // ****************************************
   logic [NUM_GPIO-1:0] gpio_dir, gpio_pol, gpio_in_stat;
   for (genvar g = 0; g < NUM_GPIO; g++) begin : g_pin
      assign gpio_dir[g] = gpio_cfg_reg[g / 4][2 * (g % 4)];
      assign gpio_pol[g] = gpio_cfg_reg[g / 4][2 * (g % 4) + 1];
      assign gpio_in_stat[g] = gpio_pin[g] == gpio_pol[g];
   end

   logic [NUM_GPIO-1:0] gpio_stat;
   logic pin17_stat, gpio_src, pin17_src, intr_src;
   assign gpio_stat = (gpio_dir & gpio_wr_reg) | (~gpio_dir & gpio_in_stat);
   assign pin17_stat = pin17_gpio && !pin_function_configuration_reg[`PIN_SEVENTEEN_DIR]
      && pin17_pin == pin_function_configuration_reg[`PIN_SEVENTEEN_POL];
   // Output pins masked by hardware; pin seventeen too, through its direction bit
   assign gpio_src = |(gpio_in_stat & ~gpio_dir & ~{mask_reg[5], mask_reg[4]});
   assign pin17_src = pin17_stat && !mask_reg[3][`S4_PIN_SEVENTEEN_BIT];
   assign intr_src = intr_stat_reg && !mask_reg[3][`S4_INTRUSION_BIT];

   // Intrusion sticks; a still-high input beats the clear bit
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         intr_stat_reg <= 1'b0;
      end else if (intr_pin) begin
         intr_stat_reg <= 1'b1;
      end else if (pin_function_configuration_reg[`PIN_INTRUSION_CLEAR]) begin
         intr_stat_reg <= 1'b0;
      end
   end

   // ****************************************
   // Register writes
   // ****************************************
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         main_configuration_reg <= `RST_MAIN_CFG;
         pin_function_configuration_reg <= `RST_PIN_CFG;
         thermal_alarm_n_lim_reg <= '{default: `RST_THERMAL_ALARM_N_LIM};
         mask_reg <= '{default: `RST_MASK};
         gpio_cfg_reg <= '{default: `RST_GPIO_CFG};
         gpio_wr_reg <= '0;
      end else if (i_reg.write) begin
         case (i_reg.addr)
            `OFS_MAIN_CFG: main_configuration_reg <= i_reg.wdata;
            `OFS_PIN_CFG: pin_function_configuration_reg <= i_reg.wdata;
            `OFS_THERMAL_ALARM_N_LIM_FIRST: thermal_alarm_n_lim_reg[0] <= i_reg.wdata;
            `OFS_THERMAL_ALARM_N_LIM_SECOND: thermal_alarm_n_lim_reg[1] <= i_reg.wdata;
            `OFS_THERMAL_ALARM_N_LIM_THIRD: thermal_alarm_n_lim_reg[2] <= i_reg.wdata;
            `OFS_STAT_FIVE: gpio_wr_reg[7:0] <= i_reg.wdata;
            `OFS_STAT_SIX: gpio_wr_reg[15:8] <= i_reg.wdata;
            default: begin
               if (i_reg.addr >= `OFS_MASK_FIRST && i_reg.addr <= `OFS_MASK_LAST) begin
                  mask_reg[i_reg.addr[2:0]] <= i_reg.wdata;
               end
               if (i_reg.addr >= `OFS_GPIO_CFG_FIRST && i_reg.addr <= `OFS_GPIO_CFG_LAST) begin
                  gpio_cfg_reg[i_reg.addr[1:0]] <= i_reg.wdata;
               end
            end
         endcase
      end
   end

   // ****************************************
   // Register reads
   // ****************************************
   logic [7:0] rdata_next, stat4;
   always_comb begin
      stat4 = 8'h00;
      stat4[`S4_TEMP_BIT] = an_stat_reg[16];
      stat4[`S4_THERMAL_ALARM_N_BIT] = thermal_alarm_n_stat_reg;
      stat4[`S4_AFC_BIT] = afc_stat_reg;
      stat4[`S4_INTRUSION_BIT] = intr_stat_reg;
      stat4[`S4_PIN_SEVENTEEN_BIT] = pin17_stat;
      rdata_next = 8'h00;
      case (i_reg.addr)
         `OFS_MAIN_CFG: rdata_next = main_configuration_reg;
         `OFS_PIN_CFG: rdata_next = pin_function_configuration_reg;
         `OFS_THERMAL_ALARM_N_LIM_FIRST: rdata_next = thermal_alarm_n_lim_reg[0];
         `OFS_THERMAL_ALARM_N_LIM_SECOND: rdata_next = thermal_alarm_n_lim_reg[1];
         `OFS_THERMAL_ALARM_N_LIM_THIRD: rdata_next = thermal_alarm_n_lim_reg[2];
         `OFS_STAT_ONE: rdata_next = an_stat_reg[7:0];
         `OFS_STAT_TWO: rdata_next = an_stat_reg[15:8];
         `OFS_STAT_THREE: rdata_next = fan_stat_reg;
         `OFS_EVENT_STAT_FOUR: rdata_next = stat4;
         `OFS_STAT_FIVE: rdata_next = gpio_stat[7:0];
         `OFS_STAT_SIX: rdata_next = gpio_stat[15:8];
         default: begin
            if (i_reg.addr >= `OFS_MASK_FIRST && i_reg.addr <= `OFS_MASK_LAST) begin
               rdata_next = mask_reg[i_reg.addr[2:0]];
            end
            if (i_reg.addr >= `OFS_GPIO_CFG_FIRST && i_reg.addr <= `OFS_GPIO_CFG_LAST) begin
               rdata_next = gpio_cfg_reg[i_reg.addr[1:0]];
            end
         end
      endcase
   end

   // Read data is registered; an unmapped address answers zero
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_reg_rdata <= 8'h00;
      end else if (i_reg.read) begin
         o_reg_rdata <= rdata_next;
      end
   end

   // ****************************************
   // Pin drivers
   // ****************************************
   logic int_any;
   assign int_any = an_latch_reg || fan_latch_reg || evt_latch_reg
      || gpio_src || pin17_src || intr_src;

   // Open-drain outputs only ever pull low
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_int_n_out <= 1'b0;
         o_int_n_oe <= 1'b0;
         o_thermal_alarm_n_out <= 1'b0;
         o_thermal_alarm_n_oe <= 1'b0;
         o_force_full_scale <= 1'b0;
      end else begin
         o_int_n_out <= 1'b0;
         o_int_n_oe <= int_any && main_configuration_reg[`MAIN_INT_ENABLE]
            && !main_configuration_reg[`MAIN_INT_CLEAR];
         o_thermal_alarm_n_out <= 1'b0;
         o_thermal_alarm_n_oe <= alarm_reg && main_configuration_reg[`MAIN_THERMAL_ALARM_N_ENABLE]
            && !pin17_gpio;
         o_force_full_scale <= (alarm_reg && main_configuration_reg[`MAIN_THERMAL_ALARM_N_ENABLE])
            || (!pin17_gpio && !pin17_pin);
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   a_int_enable_gate: assert property (
      o_int_n_oe |-> $past(main_configuration_reg[`MAIN_INT_ENABLE])
         && !$past(main_configuration_reg[`MAIN_INT_CLEAR]))
      else $error("interrupt driven while disabled");
   a_clear_drops_latches: assert property (
      int_clear |=> !an_latch_reg && !fan_latch_reg)
      else $error("latch survived a clear");
   a_analog_holdoff: assert property (
      holdoff_reg != `HOLDOFF_LOCAL_CONV |=> !an_latch_reg)
      else $error("analog latch set during hold-off");
   a_fan_holdoff: assert property (
      fan_hold_reg |=> !fan_latch_reg)
      else $error("fan latch set before fan cycle end");
   a_thermal_alarm_n_event_bit: assert property (
      thermal_alarm_n_change |=> thermal_alarm_n_stat_reg && (evt_latch_reg || $past(mask_reg[3][`S4_THERMAL_ALARM_N_BIT])))
      else $error("alarm change not flagged");
   a_afc_event_bit: assert property (
      afc_event |=> afc_stat_reg)
      else $error("fan start/stop not flagged");
   a_alarm_drive: assert property (
      o_thermal_alarm_n_oe |-> $past(alarm_reg) && !$past(pin17_gpio))
      else $error("alarm pin driven without cause");
   a_intrusion_sticky: assert property (
      intr_stat_reg && !pin_function_configuration_reg[`PIN_INTRUSION_CLEAR] |=> intr_stat_reg)
      else $error("intrusion status lost without clear");
   a_status_rewrite: assert property (
      i_meas.valid && i_meas.channel < 5'd17 && !thermal_alarm_n_change
         |=> an_stat_reg[$past(i_meas.channel)] == $past(meas_out))
      else $error("status bit not rewritten by result");
   a_fan_masked_quiet: assert property (
      !fan_masked && !fan_latch_reg |=> !fan_latch_reg)
      else $error("masked fan status set latch");

   c_analog_int: cover property (an_latch_reg ##[1:4] o_int_n_oe);
   c_clear_then_rearm: cover property (int_clear ##[1:200] an_latch_reg);
   c_alarm_forces: cover property ($rose(alarm_reg) ##2 o_force_full_scale);

endmodule
`default_nettype wire

// file: bench/host_model.sv
// Management host model that reaches the block through its register port
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input wire logic i_clock,
   output var monitor_irq_pkg::reg_req_s o_reg,
   output var logic o_ara
);
   import monitor_irq_pkg::*;
   logic [7:0] expq[$];
   initial begin
      o_reg = '0;
      o_ara = 1'b0;
   end
   // One strobe per access, held through the edge that takes it
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clock);
      o_reg <= '{1'b1, 1'b0, a, d};
      @(posedge i_clock);
      o_reg <= '0;
   endtask
   // The expected answer is noted before the strobe goes out
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      expq.push_back(e);
      @(posedge i_clock);
      o_reg <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge i_clock);
      o_reg <= '0;
   endtask
   // Alert response address seen on the bus, one pulse
   task automatic ara();
      @(posedge i_clock);
      o_ara <= 1'b1;
      @(posedge i_clock);
      o_ara <= 1'b0;
   endtask
   // Intrusion clear must be released again or it keeps clearing
   task automatic clr_intrusion(input logic [7:0] cfg3);
      wr(8'h07, cfg3 | 8'h02);
      wr(8'h07, cfg3);
   endtask
   // Polling order: event status first, first status last
   task automatic poll(input logic [7:0] e4, input logic [7:0] e1);
      rd(8'h23, e4);
      rd(8'h20, e1);
   endtask
endmodule
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench of the monitor interrupt and thermal alarm block
`timescale 1ns/1ps
`default_nettype none
`include "monitor_irq_cfg.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
   $display("Error t=%0t got %h exp %h", $time, a, b); end end
module testbench;
   import monitor_irq_pkg::*;
   logic i_clock = 1'b0;
   logic i_rst = 1'b1;
   reg_req_s reg_req;
   meas_s meas = '0;
   logic ara;
   logic intrusion = 1'b0;
   logic ext_low = 1'b0;
   logic alarm_wire;
   logic [7:0] rdata;
   logic [7:0] exp_v;
   logic int_oe;
   logic alarm_oe;
   logic full;
   logic rd_seen = 1'b0;
   logic fss = 1'b0;
   logic [15:0] gpio = 16'hffff;
   logic [15:0] lfsr = 16'h807b;
   int n_mismatch = 0;
   int checks = 0;
   always #10 i_clock = ~i_clock;
   // Alarm pin is pulled up; device or bench may pull it low
   assign alarm_wire = ~(alarm_oe | ext_low);
   host_model host (.i_clock(i_clock), .o_reg(reg_req), .o_ara(ara));
   monitor_interrupt_and_thermal_alarm dut (.i_clock(i_clock), .i_rst(i_rst),
      .i_reg(reg_req), .i_meas(meas), .i_fan('0), .i_fan_cycle_end(1'b0),
      .i_monitor_cycle_end(1'b0), .i_fan_start_stop(fss), .i_ara_received(ara),
      .i_gpio_pins(gpio), .i_thermal_alarm_n(alarm_wire),
      .i_intrusion_input(intrusion), .o_reg_rdata(rdata), .o_int_n_out(),
      .o_int_n_oe(int_oe), .o_thermal_alarm_n_out(), .o_thermal_alarm_n_oe(alarm_oe),
      .o_force_full_scale(full));
   // Watcher: read data is settled one edge after the taking edge
   always @(posedge i_clock) begin
      if (rd_seen) begin
         exp_v = host.expq.pop_front();
         `CHK(rdata, exp_v)
      end
      rd_seen <= reg_req.read;
   end
   task automatic results();
      $display("checks %0d n_mismatch %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   function automatic logic pick(input int s);
      return (s == 0) ? int_oe : full;
   endfunction
   // Bounded wait; running out of the bound ends the run
   task automatic wait_for(input int s, input logic v);
      int k;
      k = 0;
      #1;
      while (pick(s) !== v && k < 40) begin
         @(posedge i_clock);
         #1;
         k++;
      end
      `CHK(pick(s), v)
      if (pick(s) !== v) results();
   endtask
   task automatic hold(input int s, input logic v);
      repeat (8) begin
         @(posedge i_clock);
         #1;
         `CHK(pick(s), v)
      end
   endtask
   task automatic send(input logic [4:0] ch, input logic [1:0] sn, input logic [7:0] v);
      @(posedge i_clock);
      meas <= {1'b1, ch, sn, v, 8'h40, 8'h10};
      @(posedge i_clock);
      meas <= '0;
   endtask
   // Shift register step for random stimulus
   function automatic logic [15:0] lfsr_step(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // Local conversion with a random in-limit value below the thermal limit
   task automatic local_conv();
      send(5'd16, `LOCAL_SENSOR, {2'b00, lfsr[5:0]} | 8'h11);
      lfsr = lfsr_step(lfsr);
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (20) @(posedge i_clock);
      i_rst <= 1'b0;
      repeat (3) @(posedge i_clock);
      host.rd(`OFS_MAIN_CFG, `RST_MAIN_CFG);
      host.rd(`OFS_THERMAL_ALARM_N_LIM_SECOND, `RST_THERMAL_ALARM_N_LIM);
      host.rd(8'h3f, 8'h00);
      host.wr(8'h1b, 8'h80);
      host.wr(`OFS_MAIN_CFG, 8'h02);
      send(5'd3, `NO_SENSOR, 8'h40);
      hold(0, 1'b0);
      send(5'd3, `NO_SENSOR, 8'h10);
      wait_for(0, 1'b1);
      host.rd(`OFS_STAT_ONE, 8'h08);
      wait_for(0, 1'b0);
      host.rd(`OFS_STAT_ONE, 8'h08);
      hold(0, 1'b0);
      local_conv();
      hold(0, 1'b0);
      local_conv();
      wait_for(0, 1'b1);
      host.ara();
      wait_for(0, 1'b0);
      send(5'd3, `NO_SENSOR, 8'h30);
      host.rd(`OFS_STAT_ONE, 8'h00);
      intrusion <= 1'b1;
      wait_for(0, 1'b1);
      host.poll(8'h40, 8'h00);
      hold(0, 1'b1);
      host.wr(8'h1b, 8'hc0);
      wait_for(0, 1'b0);
      host.wr(8'h1b, 8'h80);
      wait_for(0, 1'b1);
      host.wr(`OFS_MAIN_CFG, 8'h06);
      wait_for(0, 1'b0);
      host.wr(`OFS_MAIN_CFG, 8'h02);
      wait_for(0, 1'b1);
      intrusion <= 1'b0;
      hold(0, 1'b1);
      host.clr_intrusion(8'h00);
      wait_for(0, 1'b0);
      host.wr(`OFS_MAIN_CFG, 8'h12);
      send(5'd0, 2'd0, 8'h51);
      wait_for(1, 1'b1);
      `CHK(alarm_oe, 1'b1)
      wait_for(0, 1'b1);
      host.poll(8'h08, 8'h01);
      wait_for(0, 1'b0);
      send(5'd0, 2'd0, 8'h4c);
      hold(1, 1'b1);
      hold(0, 1'b0);
      send(5'd0, 2'd0, 8'h4b);
      wait_for(1, 1'b0);
      wait_for(0, 1'b1);
      ext_low <= 1'b1;
      wait_for(1, 1'b1);
      host.wr(`OFS_PIN_CFG, 8'h01);
      wait_for(1, 1'b0);
      ext_low <= 1'b0;
      host.rd(`OFS_STAT_ONE, 8'h01);
      wait_for(0, 1'b0);
      host.wr(`OFS_MAIN_CFG, 8'h22);
      @(posedge i_clock) fss <= 1'b1;
      @(posedge i_clock) fss <= 1'b0;
      wait_for(0, 1'b1);
      host.rd(`OFS_EVENT_STAT_FOUR, 8'h10);
      host.ara();
      wait_for(0, 1'b0);
      lfsr = lfsr_step(lfsr);
      @(posedge i_clock) gpio <= lfsr & 16'hfffe;
      wait_for(0, 1'b1);
      host.rd(`OFS_STAT_FIVE, ~gpio[7:0]);
      host.ara();
      hold(0, 1'b1);
      results();
   end
endmodule
`default_nettype wire
